// [hdl/slr_pkg.sv]
// Constants shared by the lane configuration register bank
package slr_pkg;

    // ------------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int LANE_W = 32;   // Parallel word width of one serial lane
    localparam int NUM_LANES = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] LANE6_TERM_OFS  = 10'h2C1;
    localparam logic [9:0] LANE7_TERM_OFS  = 10'h2C2;
    localparam logic [9:0] LINK_CTRL_OFS   = 10'h300;
    localparam logic [9:0] MEAS_LAT_OFS    = 10'h302;
    localparam logic [9:0] FIXED_DELAY_OFS = 10'h304;
    localparam logic [9:0] READOUT_POS_OFS = 10'h306;
    localparam logic [9:0] CROSSBAR01_OFS  = 10'h308;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TERM_SIGN_BIT = 3;
    localparam int LINK_EN_BIT   = 0;
    localparam int LANE1_SRC_LSB = 3;
    localparam int LANE1_SRC_MSB = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] TERM_OFS_RST    = 4'h0;
    localparam logic       LINK_EN_RST     = 1'b0;
    localparam logic [4:0] MEAS_LAT_RST    = 5'h00;
    localparam logic [4:0] FIXED_DELAY_RST = 5'h00;
    localparam logic [4:0] READOUT_POS_RST = 5'h1F;
    localparam logic [2:0] LANE1_SRC_RST   = 3'h1;

    // ------------------------------------------------------------------
    // Timing: clock-enable dividers from the 200 MHz core clock
    // ------------------------------------------------------------------
    localparam logic [3:0] PCLK_DIV  = 4'h4;  // Core cycles per parallel clock
    localparam logic [3:0] FRAME_DIV = 4'h2;  // Core cycles per frame clock
    localparam logic [4:0] COUNT_MAX = 5'h1F;

    // Latency measurement states
    typedef enum logic {
        SLR_LAT_IDLE,
        SLR_LAT_COUNT
    } slr_lat_state_t;

endpackage : slr_pkg

// [hdl/slr_term_adjust.sv]
// Sign-magnitude adjustment of one lane's calibrated termination code
`timescale 1ns/1ps

module slr_term_adjust (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [2:0] cal_code,
    input  wire logic [3:0] offset,
    output logic      [2:0] term_code
);
    import slr_pkg::*;

    logic [2:0] term_code_next;
    logic [3:0] sum;

    // ------------------------------------------------------------------
    // Add or subtract the magnitude, clamped to the 3-bit code range
    // ------------------------------------------------------------------
    always_comb begin
        sum = 4'h0;
        if (offset[TERM_SIGN_BIT]) begin
            if (cal_code < offset[2:0]) begin
                term_code_next = 3'h0;  // Clamp rather than wrap to high value
            end else begin
                term_code_next = cal_code - offset[2:0];
            end
        end else begin
            sum = {1'b0, cal_code} + {1'b0, offset[2:0]};
            term_code_next = sum[3] ? 3'h7 : sum[2:0];
        end
    end

    // Registered so the analog trim sees a glitch-free code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            term_code <= 3'h0;
        end else begin
            term_code <= term_code_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    term_add_a : assert property (
        rst_n && !offset[TERM_SIGN_BIT] |=> term_code >= $past(cal_code))
        else $error("positive offset lowered termination code");

endmodule : slr_term_adjust

// [hdl/slr_lane_config.sv]
// Receiver lane configuration and status register bank
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Operation
// - Separate 4-bit offsets trim lanes six, seven
// - Offset top bit subtracts, low three magnitude
// - Link enable starts receiver after full setup
// - Report measured link latency in parallel clocks
// - Delay global multiframe clock by frame cycles
// - Buffer read-out at programmed multiframe position
// - Three-bit selector picks logical lane one source
// - Lane one selector resets to input one
module slr_lane_config (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic [slr_pkg::ADDR_W-1:0]  addr,
    input  wire logic [slr_pkg::DATA_W-1:0]  wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [slr_pkg::DATA_W-1:0]  rd_data,
    input  wire logic [2:0]                  lane6_cal_code,
    input  wire logic [2:0]                  lane7_cal_code,
    output logic      [2:0]                  lane6_term_code,
    output logic      [2:0]                  lane7_term_code,
    output logic                             link_enable,
    input  wire logic                        global_lmfc,
    input  wire logic                        deframer_lmfc,
    output logic                             global_lmfc_delayed,
    output logic                             buffer_readout,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_0,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_1,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_2,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_3,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_4,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_5,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_6,
    input  wire logic [slr_pkg::LANE_W-1:0]  serial_input_7,
    output logic      [slr_pkg::LANE_W-1:0]  logical_lane1
);
    import slr_pkg::*;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic [3:0]     term6_reg,        term6_next;
    logic [3:0]     term7_reg,        term7_next;
    logic           link_en_reg,      link_en_next;
    logic [4:0]     fixed_delay_reg,  fixed_delay_next;
    logic [4:0]     readout_pos_reg,  readout_pos_next;
    logic [2:0]     lane1_src_reg,    lane1_src_next;
    logic [4:0]     meas_lat_reg,     meas_lat_next;
    logic [7:0]     rd_data_reg,      rd_data_next;

    // Store only the defined fields; reserved bits are never held
    always_comb begin
        term6_next       = term6_reg;
        term7_next       = term7_reg;
        link_en_next     = link_en_reg;
        fixed_delay_next = fixed_delay_reg;
        readout_pos_next = readout_pos_reg;
        lane1_src_next   = lane1_src_reg;
        if (wr_en) begin
            if (addr == LANE6_TERM_OFS) begin
                term6_next = wr_data[3:0];
            end else if (addr == LANE7_TERM_OFS) begin
                term7_next = wr_data[3:0];
            end else if (addr == LINK_CTRL_OFS) begin
                link_en_next = wr_data[LINK_EN_BIT];
            end else if (addr == FIXED_DELAY_OFS) begin
                fixed_delay_next = wr_data[4:0];
            end else if (addr == READOUT_POS_OFS) begin
                // Not range-checked: software keeps this within limit
                readout_pos_next = wr_data[4:0];
            end else if (addr == CROSSBAR01_OFS) begin
                lane1_src_next = wr_data[LANE1_SRC_MSB:LANE1_SRC_LSB];
            end
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_comb begin
        rd_data_next = 8'h00;
        if (rd_en) begin
            if (addr == LANE6_TERM_OFS) begin
                rd_data_next = {4'h0, term6_reg};
            end else if (addr == LANE7_TERM_OFS) begin
                rd_data_next = {4'h0, term7_reg};
            end else if (addr == LINK_CTRL_OFS) begin
                rd_data_next = {7'h00, link_en_reg};
            end else if (addr == MEAS_LAT_OFS) begin
                rd_data_next = {3'h0, meas_lat_reg};
            end else if (addr == FIXED_DELAY_OFS) begin
                rd_data_next = {3'h0, fixed_delay_reg};
            end else if (addr == READOUT_POS_OFS) begin
                rd_data_next = {3'h0, readout_pos_reg};
            end else if (addr == CROSSBAR01_OFS) begin
                rd_data_next = {2'h0, lane1_src_reg, 3'h0};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            term6_reg       <= TERM_OFS_RST;
            term7_reg       <= TERM_OFS_RST;
            link_en_reg     <= LINK_EN_RST;
            fixed_delay_reg <= FIXED_DELAY_RST;
            readout_pos_reg <= READOUT_POS_RST;
            lane1_src_reg   <= LANE1_SRC_RST;
            rd_data_reg     <= 8'h00;
        end else begin
            term6_reg       <= term6_next;
            term7_reg       <= term7_next;
            link_en_reg     <= link_en_next;
            fixed_delay_reg <= fixed_delay_next;
            readout_pos_reg <= readout_pos_next;
            lane1_src_reg   <= lane1_src_next;
            rd_data_reg     <= rd_data_next;
        end
    end

    assign rd_data     = rd_data_reg;
    assign link_enable = link_en_reg;

    // ------------------------------------------------------------------
    // Parallel and frame clock enables from free-running dividers
    // ------------------------------------------------------------------
    logic [3:0] pclk_div_reg,  pclk_div_next;
    logic [3:0] frame_div_reg, frame_div_next;
    logic       pclk_en;
    logic       frame_en;

    assign pclk_en  = (pclk_div_reg == PCLK_DIV - 4'h1);
    assign frame_en = (frame_div_reg == FRAME_DIV - 4'h1);

    always_comb begin
        pclk_div_next  = pclk_en  ? 4'h0 : pclk_div_reg + 4'h1;
        frame_div_next = frame_en ? 4'h0 : frame_div_reg + 4'h1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pclk_div_reg  <= 4'h0;
            frame_div_reg <= 4'h0;
        end else begin
            pclk_div_reg  <= pclk_div_next;
            frame_div_reg <= frame_div_next;
        end
    end

    // ------------------------------------------------------------------
    // Link timing: fixed delay, latency measurement, buffer read-out
    // ------------------------------------------------------------------
    logic [4:0]     dly_cnt_reg,    dly_cnt_next;
    logic           dly_busy_reg,   dly_busy_next;
    logic           glob_dly_reg,   glob_dly_next;
    slr_lat_state_t lat_state_reg,  lat_state_next;
    logic [4:0]     lat_cnt_reg,    lat_cnt_next;
    logic [4:0]     rx_phase_reg,   rx_phase_next;
    logic           readout_reg,    readout_next;

    // A new global edge restarts the delay; an idle link clears the delay busy flag, latency state and receive phase
    always_comb begin
        dly_cnt_next   = dly_cnt_reg;
        dly_busy_next  = dly_busy_reg;
        glob_dly_next  = 1'b0;
        lat_state_next = lat_state_reg;
        lat_cnt_next   = lat_cnt_reg;
        meas_lat_next  = meas_lat_reg;
        rx_phase_next  = rx_phase_reg;
        readout_next   = 1'b0;
        if (!link_en_reg) begin
            dly_busy_next  = 1'b0;
            lat_state_next = SLR_LAT_IDLE;
            rx_phase_next  = 5'h00;
        end else begin
            // Fixed delay counted in frame clock cycles
            if (global_lmfc) begin
                if (fixed_delay_reg == 5'h00) begin
                    glob_dly_next = 1'b1;
                    dly_busy_next = 1'b0;
                end else begin
                    dly_cnt_next  = fixed_delay_reg;
                    dly_busy_next = 1'b1;
                end
            end else if (dly_busy_reg && frame_en) begin
                dly_cnt_next = dly_cnt_reg - 5'h01;
                if (dly_cnt_reg == 5'h01) begin
                    glob_dly_next = 1'b1;
                    dly_busy_next = 1'b0;
                end
            end
            // Latency from delayed global edge to deframer edge
            case (lat_state_reg)
                SLR_LAT_IDLE: begin
                    if (glob_dly_reg) begin
                        lat_cnt_next   = 5'h00;
                        lat_state_next = SLR_LAT_COUNT;
                    end
                end
                SLR_LAT_COUNT: begin
                    if (deframer_lmfc) begin
                        meas_lat_next  = lat_cnt_reg;
                        lat_state_next = SLR_LAT_IDLE;
                    end else if (glob_dly_reg) begin
                        lat_cnt_next = 5'h00;  // Newest global edge is the reference
                    end else if (pclk_en && lat_cnt_reg != COUNT_MAX) begin
                        lat_cnt_next = lat_cnt_reg + 5'h01;
                    end
                end
                default: lat_state_next = SLR_LAT_IDLE;
            endcase
            // Receive multiframe phase; read-out at programmed position
            if (deframer_lmfc) begin
                rx_phase_next = 5'h00;
            end else if (pclk_en && rx_phase_reg != COUNT_MAX) begin
                rx_phase_next = rx_phase_reg + 5'h01;
            end
            readout_next = pclk_en && (rx_phase_reg == readout_pos_reg);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dly_cnt_reg   <= 5'h00;
            dly_busy_reg  <= 1'b0;
            glob_dly_reg  <= 1'b0;
            lat_state_reg <= SLR_LAT_IDLE;
            lat_cnt_reg   <= 5'h00;
            meas_lat_reg  <= MEAS_LAT_RST;
            rx_phase_reg  <= 5'h00;
            readout_reg   <= 1'b0;
        end else begin
            dly_cnt_reg   <= dly_cnt_next;
            dly_busy_reg  <= dly_busy_next;
            glob_dly_reg  <= glob_dly_next;
            lat_state_reg <= lat_state_next;
            lat_cnt_reg   <= lat_cnt_next;
            meas_lat_reg  <= meas_lat_next;
            rx_phase_reg  <= rx_phase_next;
            readout_reg   <= readout_next;
        end
    end

    assign global_lmfc_delayed = glob_dly_reg;
    assign buffer_readout      = readout_reg;

    // ------------------------------------------------------------------
    // Crossbar for logical lane 1
    // ------------------------------------------------------------------
    logic [LANE_W-1:0] lanes [NUM_LANES];
    logic [LANE_W-1:0] lane1_reg, lane1_next;

    assign lanes[0] = serial_input_0;
    assign lanes[1] = serial_input_1;
    assign lanes[2] = serial_input_2;
    assign lanes[3] = serial_input_3;
    assign lanes[4] = serial_input_4;
    assign lanes[5] = serial_input_5;
    assign lanes[6] = serial_input_6;
    assign lanes[7] = serial_input_7;

    always_comb begin
        lane1_next = lanes[lane1_src_reg];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lane1_reg <= '0;
        end else begin
            lane1_reg <= lane1_next;
        end
    end

    assign logical_lane1 = lane1_reg;

    // ------------------------------------------------------------------
    // Termination trim, one instance each for lanes six and seven
    // ------------------------------------------------------------------
    slr_term_adjust u_term6 (
        .clock     (clock),
        .rst_n     (rst_n),
        .cal_code  (lane6_cal_code),
        .offset    (term6_reg),
        .term_code (lane6_term_code)
    );

    slr_term_adjust u_term7 (
        .clock     (clock),
        .rst_n     (rst_n),
        .cal_code  (lane7_cal_code),
        .offset    (term7_reg),
        .term_code (lane7_term_code)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    term_write_a : assert property (
        wr_en && addr == LANE6_TERM_OFS |=> term6_reg == $past(wr_data[3:0]))
        else $error("lane six offset not stored");
    reserved_zero_a : assert property (
        rd_en && addr == CROSSBAR01_OFS |=> rd_data[7:6] == 2'h0 && rd_data[2:0] == 3'h0)
        else $error("reserved crossbar bits read nonzero");
    link_enable_a : assert property (
        wr_en && addr == LINK_CTRL_OFS |=> link_enable == $past(wr_data[0]))
        else $error("link enable does not follow write");
    latency_latch_a : assert property (
        link_en_reg && lat_state_reg == SLR_LAT_COUNT && deframer_lmfc
        |=> meas_lat_reg == $past(lat_cnt_reg))
        else $error("measured latency not captured");
    delay_zero_a : assert property (
        link_en_reg && global_lmfc && fixed_delay_reg == 5'h00 |=> global_lmfc_delayed)
        else $error("zero delay edge not passed at once");
    readout_pos_a : assert property (
        buffer_readout |-> $past(rx_phase_reg) == $past(readout_pos_reg) && $past(pclk_en))
        else $error("read-out strobe at wrong position");
    readout_store_a : assert property (
        wr_en && addr == READOUT_POS_OFS |=> readout_pos_reg == $past(wr_data[4:0]))
        else $error("read-out position not stored");
    lane_select_a : assert property (
        rst_n |=> logical_lane1 == $past(lanes[lane1_src_reg]))
        else $error("logical lane one source mismatch");
    delayed_edge_c : cover property (dly_busy_reg ##[1:200] global_lmfc_delayed);
    latency_meas_c : cover property (lat_state_reg == SLR_LAT_COUNT ##1
                                     lat_state_reg == SLR_LAT_IDLE);
    readout_seen_c : cover property (buffer_readout);

endmodule : slr_lane_config

// [test/slr_lane_source.sv]
// Behavioural far-end transmitter: parallel lane words and receive multiframe edges
`timescale 1ns/1ps

module slr_lane_source (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        send_edge,
    output logic      [31:0] lane_word [8],
    output logic             deframer_lmfc
);
    logic [23:0] stamp_reg;
    logic [23:0] stamp_next;

    // ------------------------------------------------------------------
    // Running stamp and multiframe edge
    // ------------------------------------------------------------------
    // The stamp moves every cycle, so a stale or wrongly routed word never matches
    always_comb begin
        stamp_next = stamp_reg + 24'h000001;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stamp_reg     <= 24'h000000;
            deframer_lmfc <= 1'b0;
        end else begin
            stamp_reg     <= stamp_next;
            deframer_lmfc <= send_edge;  // One-cycle edge, one cycle after the request
        end
    end

    // Lane number in the top byte tells the eight inputs apart
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lane_word[i] = {8'(i), stamp_reg};
        end
    end
endmodule : slr_lane_source

// [test/slr_lane_config_test.sv]
// Self-checking testbench for the lane configuration register bank
`timescale 1ns/1ps

`define CHECK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end

module slr_lane_config_test;
    import slr_pkg::*;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [2:0]        cal6 = 3'h5;
    logic [2:0]        cal7 = 3'h2;
    logic [2:0]        term6, term7;
    logic              link_enable, global_lmfc = 1'b0, deframer_lmfc;
    logic              lmfc_delayed, buffer_readout, send_edge = 1'b0;
    logic [31:0]       lane_word [8];
    logic [31:0]       logical_lane1, exp_word;
    int                fails = 0, check_count = 0, n;
    logic [9:0] t_addr [8] = '{10'h2C1, 10'h2C2, 10'h300, 10'h302, 10'h304, 10'h306, 10'h308, 10'h301};
    logic [7:0] t_rst  [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h08, 8'h00};
    logic [7:0] t_wv   [8] = '{8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'hEA, 8'hFF, 8'hFF};
    logic [7:0] t_exp  [8] = '{8'h0F, 8'h0F, 8'h00, 8'h00, 8'h1F, 8'h0A, 8'h38, 8'h00};

    always #2.5 clock = ~clock;

    slr_lane_config u_slr_lane_config (.clock(clock), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .lane6_cal_code(cal6), .lane7_cal_code(cal7), .lane6_term_code(term6),
        .lane7_term_code(term7), .link_enable(link_enable), .global_lmfc(global_lmfc),
        .deframer_lmfc(deframer_lmfc), .global_lmfc_delayed(lmfc_delayed),
        .buffer_readout(buffer_readout), .serial_input_0(lane_word[0]),
        .serial_input_1(lane_word[1]), .serial_input_2(lane_word[2]),
        .serial_input_3(lane_word[3]), .serial_input_4(lane_word[4]),
        .serial_input_5(lane_word[5]), .serial_input_6(lane_word[6]),
        .serial_input_7(lane_word[7]), .logical_lane1(logical_lane1));

    slr_lane_source u_slr_lane_source (.clock(clock), .rst_n(rst_n), .send_edge(send_edge),
        .lane_word(lane_word), .deframer_lmfc(deframer_lmfc));

    // ------------------------------------------------------------------
    // Bus and handshake tasks
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic reg_read(input logic [9:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_read

    task automatic pulse(input bit to_far_end);
        @(posedge clock);
        if (to_far_end) send_edge <= 1'b1; else global_lmfc <= 1'b1;
        @(posedge clock);
        send_edge <= 1'b0;
        global_lmfc <= 1'b0;
    endtask : pulse

    // Bounded wait: a missing pulse counts as a mismatch and ends the run
    task automatic wait_pulse(input bit sel, output int cnt);
        // The pulse may already stand after the edge that took the request
        cnt = 1;
        #1;
        while (((sel ? buffer_readout : lmfc_delayed) !== 1'b1) && cnt < 200) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        if (cnt >= 200) begin
            fails++;
            final_report();
        end
    endtask : wait_pulse

    function automatic logic [2:0] term_exp(input logic [2:0] cal, input logic [3:0] ofs);
        int v;
        v = ofs[3] ? int'(cal) - int'(ofs[2:0]) : int'(cal) + int'(ofs[2:0]);
        return (v < 0) ? 3'h0 : (v > 7) ? 3'h7 : 3'(v);
    endfunction : term_exp

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] d;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, masked write-back, read-only and unmapped places
        for (int i = 0; i < 8; i++) begin
            reg_read(t_addr[i], d);
            `CHECK("reset value", t_rst[i], d)
            reg_write(t_addr[i], t_wv[i]);
            reg_read(t_addr[i], d);
            `CHECK("written value", t_exp[i], d)
        end
        $display("test registers done");
        // Every offset code on both lanes, each lane with its own calibration
        for (int o = 0; o < 16; o++) begin
            reg_write(10'h2C1, 8'(o));
            reg_write(10'h2C2, 8'(15 - o));
            repeat (2) @(posedge clock);
            #1;
            `CHECK("lane6 term", term_exp(cal6, 4'(o)), term6)
            `CHECK("lane7 term", term_exp(cal7, 4'(15 - o)), term7)
        end
        $display("test termination done");
        // Every selector code routes its own input to logical lane 1
        for (int s = 7; s >= 0; s--) begin
            reg_write(10'h308, 8'(s << 3));
            @(posedge clock);
            exp_word = lane_word[s];
            #1;
            `CHECK("logical lane1", exp_word, logical_lane1)
        end
        $display("test crossbar done");
        // Link up after setup; zero and nonzero fixed delay, then latency
        reg_write(10'h304, 8'h00);
        reg_write(10'h300, 8'h01);
        #1;
        `CHECK("link enable", 1'b1, link_enable)
        pulse(1'b0);
        wait_pulse(1'b0, n);
        `CHECK("zero delay", 1, n)
        reg_write(10'h304, 8'h03);
        pulse(1'b0);
        wait_pulse(1'b0, n);
        `CHECK("fixed delay", 1'b1, n >= 5 && n <= 7)
        repeat (19) @(posedge clock);
        pulse(1'b1);
        repeat (3) @(posedge clock);
        reg_read(10'h302, d);
        `CHECK("latency", 1'b1, d >= 8'h04 && d <= 8'h06)
        $display("test link timing done");
        // Read-out at position two lands 6 to 12 core cycles after the edge
        reg_write(10'h306, 8'h02);
        repeat (3) @(posedge clock);
        pulse(1'b1);
        wait_pulse(1'b1, n);
        `CHECK("readout position", 1'b1, n >= 6 && n <= 12)
        // Clearing link enable idles the read-out strobe
        reg_write(10'h300, 8'h00);
        pulse(1'b1);
        n = 0;
        repeat (40) begin
            @(posedge clock);
            #1;
            if (buffer_readout === 1'b1) n++;
        end
        `CHECK("idle readout", 0, n)
        `CHECK("link disabled", 1'b0, link_enable)
        $display("test readout done");
        final_report();
    end
endmodule : slr_lane_config_test
